// [hw/eais_defines.vh]
// Constants shared by the E1 alarm indication generate and detect block.
`ifndef EAIS_DEFINES_VH
`define EAIS_DEFINES_VH

// Register byte offsets.
`define EAIS_OFF_CTRL        12'h000
`define EAIS_OFF_IRQ_STAT    12'h004
`define EAIS_OFF_IRQ_MASK    12'h008
`define EAIS_OFF_STATUS      12'h00c

// Control register fields.
`define EAIS_TXSEL_HI        3
`define EAIS_TXSEL_LO        2
`define EAIS_RXCRIT_HI       1
`define EAIS_RXCRIT_LO       0
`define EAIS_CTRL_RESET      2'b00

// Transmit pattern select codes.
`define EAIS_TX_NORMAL       2'b00
`define EAIS_TX_UNFRAMED     2'b01
`define EAIS_TX_SLOT16       2'b10
`define EAIS_TX_FRAMED       2'b11

// Receive declaration criteria codes.
`define EAIS_RX_OFF          2'b00
`define EAIS_RX_ANY          2'b01
`define EAIS_RX_SLOT16       2'b10
`define EAIS_RX_FRAMED       2'b11

// Interrupt status bits.
`define EAIS_IRQ_RISE        0
`define EAIS_IRQ_FALL        1
`define EAIS_IRQ_W           2

// E1 frame geometry: 32 timeslots of 8 bits.
`define EAIS_POS_W           8
`define EAIS_POS_LAST        8'hff
`define EAIS_POS_ZERO        8'h00
`define EAIS_SLOT_FAS        5'h00
`define EAIS_SLOT_SIG        5'h10

`endif

// [hw/eais_rx_detect.v]
// Receive side alarm indication pattern detector for one E1 channel.
`timescale 1ns/100ps
`include "eais_defines.vh"

module eais_rx_detect #(
  parameter ZERO_LIMIT  = 3,
  parameter SET_FRAMES  = 2,
  parameter CLR_FRAMES  = 2
) (
  // Clock and reset.
  input  wire       pclk,
  input  wire       presetn,
  // Receive bit stream from the framer.
  input  wire       rx_bit_en,
  input  wire       rx_bit,
  input  wire       rx_frame_start,
  input  wire       rx_in_frame,
  // Configuration and result.
  input  wire [1:0] criteria,
  output reg        defect_q
);

  reg  [`EAIS_POS_W-1:0] pos_q;
  reg  [8:0]             zero_all_q;
  reg  [8:0]             zero_pay_q;
  reg                    slot16_zero_q;
  reg                    framed_q;
  reg  [3:0]             hit_cnt_q;
  reg  [3:0]             miss_cnt_q;
  wire [`EAIS_POS_W-1:0] pos_cur;
  wire [4:0]             slot;
  wire                   is_zero;
  wire                   frame_end;
  wire [8:0]             zall_n;
  wire [8:0]             zpay_n;
  wire                   s16z_n;
  wire                   frm_n;
  wire                   unframed_ones;
  wire                   framed_ones;
  wire                   slot16_ones;
  reg                    match;

  assign pos_cur   = rx_frame_start ? `EAIS_POS_ZERO : pos_q;
  assign slot      = pos_cur[`EAIS_POS_W-1:3];
  assign is_zero   = ~rx_bit;
  assign frame_end = rx_bit_en && (pos_cur == `EAIS_POS_LAST);
  // Counts include the current bit so the frame-end decision sees the full frame.
  assign zall_n = (pos_cur == `EAIS_POS_ZERO ? 9'h000 : zero_all_q) + {8'h00, is_zero};
  assign zpay_n = (pos_cur == `EAIS_POS_ZERO ? 9'h000 : zero_pay_q)
                  + {8'h00, is_zero && (slot != `EAIS_SLOT_FAS)};
  assign s16z_n = (pos_cur == `EAIS_POS_ZERO ? 1'b0 : slot16_zero_q)
                  | (is_zero && (slot == `EAIS_SLOT_SIG));
  assign frm_n  = (pos_cur == `EAIS_POS_ZERO ? 1'b1 : framed_q) & rx_in_frame;

  assign unframed_ones = !frm_n && (zall_n < ZERO_LIMIT);
  assign framed_ones   = frm_n && (zpay_n < ZERO_LIMIT);
  assign slot16_ones   = frm_n && !s16z_n;

  always @*
  begin
    case (criteria)
      `EAIS_RX_OFF:    match = 1'b0;
      `EAIS_RX_ANY:    match = unframed_ones | framed_ones;
      `EAIS_RX_SLOT16: match = slot16_ones;
      `EAIS_RX_FRAMED: match = framed_ones;
      default:         match = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q         <= `EAIS_POS_ZERO;
      zero_all_q    <= 9'h000;
      zero_pay_q    <= 9'h000;
      slot16_zero_q <= 1'b0;
      framed_q      <= 1'b1;
      hit_cnt_q     <= 4'h0;
      miss_cnt_q    <= 4'h0;
      defect_q      <= 1'b0;
    end
    else
    begin
      if (criteria == `EAIS_RX_OFF)
      begin
        defect_q   <= 1'b0;
        hit_cnt_q  <= 4'h0;
        miss_cnt_q <= 4'h0;
      end
      else if (frame_end)
      begin
        // Declaration and clearing both need consecutive frames to avoid chatter.
        if (match)
        begin
          miss_cnt_q <= 4'h0;
          if (hit_cnt_q >= SET_FRAMES[3:0] - 4'h1)
            defect_q <= 1'b1;
          else
            hit_cnt_q <= hit_cnt_q + 4'h1;
        end
        else
        begin
          hit_cnt_q <= 4'h0;
          if (miss_cnt_q >= CLR_FRAMES[3:0] - 4'h1)
            defect_q <= 1'b0;
          else
            miss_cnt_q <= miss_cnt_q + 4'h1;
        end
      end
      if (rx_bit_en)
      begin
        pos_q         <= pos_cur + 8'h01;
        zero_all_q    <= zall_n;
        zero_pay_q    <= zpay_n;
        slot16_zero_q <= s16z_n;
        framed_q      <= frm_n;
      end
    end
  end

endmodule

// [hw/eais_top.v]
// E1 alarm indication generate and detect block with APB registers.
// Notes on behaviour
// - Transmit select 00 passes normal E1 traffic unchanged.
// - Transmit select 01 sends continuous unframed all ones, no framing bits.
// - Transmit select 10 forces timeslot 16 to all ones, others unchanged.
// - Transmit select 11 sends all-ones payload while keeping timeslot 0 framing.
// - Both two-bit fields are read/write and reset to 00.
// - Nonzero transmit select forces the pattern regardless of receive state.
// - Criteria 00 never declares the alarm defect.
// - Criteria 01 declares on unframed or framed all ones.
// - Criteria 10 declares only on all ones in timeslot 16 of a framed signal, ignoring unframed.
// - Criteria 11 declares only on framed all ones, ignoring unframed.
`timescale 1ns/100ps
`include "eais_defines.vh"

module eais_top #(
  parameter ZERO_LIMIT  = 3,
  parameter SET_FRAMES  = 2,
  parameter CLR_FRAMES  = 2
) (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Transmit stream from the framer.
  input  wire        tx_bit_en,
  input  wire        tx_bit_in,
  input  wire        tx_frame_start,
  output reg         tx_bit_out,
  output reg         tx_bit_valid,
  // Receive stream from the framer.
  input  wire        rx_bit_en,
  input  wire        rx_bit,
  input  wire        rx_frame_start,
  input  wire        rx_in_frame,
  // Status and interrupt.
  output reg         ais_defect,
  output reg         irq
);

  reg  [1:0]                 tx_sel_q;
  reg  [1:0]                 rx_crit_q;
  reg  [`EAIS_IRQ_W-1:0]     irq_stat_q;
  reg  [`EAIS_IRQ_W-1:0]     irq_mask_q;
  reg  [`EAIS_IRQ_W-1:0]     irq_stat_d;
  reg  [`EAIS_POS_W-1:0]     tx_pos_q;
  reg                        defect_prev_q;
  reg                        tx_bit_d;
  reg  [31:0]                rdata_d;
  reg                        err_d;
  wire                       defect;
  wire                       setup_ph;
  wire                       wr_take;
  wire [`EAIS_POS_W-1:0]     tx_pos_cur;
  wire [4:0]                 tx_slot;
  wire [`EAIS_IRQ_W-1:0]     irq_set;

  // Known register offsets answer without error.
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `EAIS_OFF_CTRL) || (a == `EAIS_OFF_IRQ_STAT) ||
                (a == `EAIS_OFF_IRQ_MASK) || (a == `EAIS_OFF_STATUS);
    end
  endfunction

  assign setup_ph = psel && !penable;
  assign wr_take  = psel && penable && pready && pwrite && !pslverr;

  // Read data and error are prepared in the setup cycle, so the access completes with no wait state.
  always @*
  begin
    rdata_d = 32'h0000_0000;
    err_d   = !addr_ok(paddr);
    case (paddr)
      `EAIS_OFF_CTRL:
      begin
        rdata_d[`EAIS_TXSEL_HI:`EAIS_TXSEL_LO]   = tx_sel_q;
        rdata_d[`EAIS_RXCRIT_HI:`EAIS_RXCRIT_LO] = rx_crit_q;
      end
      `EAIS_OFF_IRQ_STAT: rdata_d[`EAIS_IRQ_W-1:0] = irq_stat_q;
      `EAIS_OFF_IRQ_MASK: rdata_d[`EAIS_IRQ_W-1:0] = irq_mask_q;
      `EAIS_OFF_STATUS:   rdata_d[0] = defect;
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata  <= rdata_d;
      pready  <= 1'b1;
      pslverr <= err_d;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control and mask registers.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_sel_q   <= `EAIS_CTRL_RESET;
      rx_crit_q  <= `EAIS_CTRL_RESET;
      irq_mask_q <= {`EAIS_IRQ_W{1'b0}};
    end
    else if (wr_take)
    begin
      if (paddr == `EAIS_OFF_CTRL)
      begin
        tx_sel_q  <= pwdata[`EAIS_TXSEL_HI:`EAIS_TXSEL_LO];
        rx_crit_q <= pwdata[`EAIS_RXCRIT_HI:`EAIS_RXCRIT_LO];
      end
      if (paddr == `EAIS_OFF_IRQ_MASK)
        irq_mask_q <= pwdata[`EAIS_IRQ_W-1:0];
    end
  end

  assign irq_set = {defect_prev_q & ~defect, ~defect_prev_q & defect};

  // A new event in the same cycle as a write-one clear stays set.
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (wr_take && (paddr == `EAIS_OFF_IRQ_STAT))
      irq_stat_d = irq_stat_q & ~pwdata[`EAIS_IRQ_W-1:0];
    irq_stat_d = irq_stat_d | irq_set;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q    <= {`EAIS_IRQ_W{1'b0}};
      defect_prev_q <= 1'b0;
      irq           <= 1'b0;
      ais_defect    <= 1'b0;
    end
    else
    begin
      irq_stat_q    <= irq_stat_d;
      defect_prev_q <= defect;
      irq           <= |(irq_stat_d & irq_mask_q);
      ais_defect    <= defect;
    end
  end

  // Transmit bit position within the 256-bit E1 frame.
  assign tx_pos_cur = tx_frame_start ? `EAIS_POS_ZERO : tx_pos_q;
  assign tx_slot    = tx_pos_cur[`EAIS_POS_W-1:3];

  // The pattern depends only on the select field, never on receive alarms.
  always @*
  begin
    case (tx_sel_q)
      `EAIS_TX_NORMAL:   tx_bit_d = tx_bit_in;
      `EAIS_TX_UNFRAMED: tx_bit_d = 1'b1;
      `EAIS_TX_SLOT16:
        tx_bit_d = (tx_slot == `EAIS_SLOT_SIG) ? 1'b1 : tx_bit_in;
      `EAIS_TX_FRAMED:
        tx_bit_d = (tx_slot == `EAIS_SLOT_FAS) ? tx_bit_in : 1'b1;
      default:           tx_bit_d = tx_bit_in;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_pos_q     <= `EAIS_POS_ZERO;
      tx_bit_out   <= 1'b1;
      tx_bit_valid <= 1'b0;
    end
    else
    begin
      tx_bit_valid <= tx_bit_en;
      if (tx_bit_en)
      begin
        tx_pos_q   <= tx_pos_cur + 8'h01;
        tx_bit_out <= tx_bit_d;
      end
    end
  end

  eais_rx_detect #(
    .ZERO_LIMIT (ZERO_LIMIT),
    .SET_FRAMES (SET_FRAMES),
    .CLR_FRAMES (CLR_FRAMES)
  ) u_detect (
    .pclk           (pclk),
    .presetn        (presetn),
    .rx_bit_en      (rx_bit_en),
    .rx_bit         (rx_bit),
    .rx_frame_start (rx_frame_start),
    .rx_in_frame    (rx_in_frame),
    .criteria       (rx_crit_q),
    .defect_q       (defect)
  );

endmodule

// [tb/eais_far_end.sv]
// Far-end E1 equipment model that drives the receive bit stream.
`timescale 1ns/100ps
module eais_far_end (
  // Clock, reset and pattern choice: 0 live, 1 unframed ones, 2 framed ones, 3 slot 16 ones.
  input  wire       pclk,
  input  wire       presetn,
  input  wire [1:0] mode,
  // Receive stream toward the block.
  output logic      rx_bit_en,
  output logic      rx_bit,
  output logic      rx_frame_start,
  output logic      rx_in_frame
);
  logic [7:0] pos_q;
  logic [4:0] slot;
  assign slot = pos_q[7:3];
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      pos_q <= 8'h00;
    else
      pos_q <= pos_q + 8'h01;
  // Live traffic alternates bits so that it never looks like all ones.
  always @*
  begin
    rx_bit_en = presetn;
    rx_frame_start = presetn && (pos_q == 8'h00);
    rx_in_frame = (mode != 2'b01);
    case (mode)
      2'b01: rx_bit = 1'b1;
      2'b10: rx_bit = (slot == 5'h00) ? pos_q[0] : 1'b1;
      2'b11: rx_bit = (slot == 5'h10) | pos_q[0];
      default: rx_bit = pos_q[0];
    endcase
  end
endmodule

// [tb/eais_checker_asserts.sv]
// Concurrent checks on the ports of the alarm indication block.
`timescale 1ns/100ps
module eais_checker (
  // Clock, reset and register bus.
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Streams, status and interrupt.
  input wire        tx_bit_en,
  input wire        tx_bit_in,
  input wire        tx_frame_start,
  input wire        tx_bit_out,
  input wire        tx_bit_valid,
  input wire        rx_bit_en,
  input wire        rx_bit,
  input wire        rx_frame_start,
  input wire        rx_in_frame,
  input wire        ais_defect,
  input wire        irq
);
  logic [1:0] sel_q;
  logic [1:0] crit_q;
  logic [1:0] mask_q;
  logic [7:0] pos_q;
  logic [7:0] cur_pos;
  logic       wr_ok;
  logic       unmapped;
  assign wr_ok = psel && penable && pready && !pslverr && pwrite;
  assign cur_pos = tx_frame_start ? 8'h00 : pos_q + 8'h01;
  assign unmapped = (paddr[1:0] != 2'b00) || (paddr > 12'h00c);
  // Shadow copies of the control and mask registers, updated at the commit edge.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sel_q <= 2'b00;
      crit_q <= 2'b00;
      mask_q <= 2'b00;
      pos_q <= 8'hff;
    end
    else
    begin
      if (wr_ok && paddr == 12'h000)
      begin
        sel_q <= pwdata[3:2];
        crit_q <= pwdata[1:0];
      end
      if (wr_ok && paddr == 12'h008)
        mask_q <= pwdata[1:0];
      if (tx_bit_en)
        pos_q <= cur_pos;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_crit_off;
    crit_q == 2'b00 [*2];
  endsequence
  a_ready_pulse: assert property (s_setup |=> pready ##1 !pready) else $error("pready not one cycle");
  a_bus_error: assert property (s_setup |=> pslverr == $past(unmapped)) else $error("pslverr wrong");
  a_ctrl_readback: assert property (s_setup ##0 (!pwrite && paddr == 12'h000) |=> prdata == {28'h0, sel_q, crit_q})
    else $error("control readback wrong");
  a_tx_normal: assert property (tx_bit_en && sel_q == 2'b00 |=> tx_bit_out == $past(tx_bit_in) && tx_bit_valid)
    else $error("normal traffic altered");
  a_tx_unframed: assert property (tx_bit_en && sel_q == 2'b01 |=> tx_bit_out) else $error("unframed ones missing");
  a_tx_slot16: assert property (tx_bit_en && sel_q == 2'b10 |=> tx_bit_out == ($past(cur_pos[7:3] == 5'h10) | $past(tx_bit_in)))
    else $error("slot 16 pattern wrong");
  a_tx_framed: assert property (tx_bit_en && sel_q == 2'b11 |=> tx_bit_out == ($past(cur_pos[7:3] == 5'h00) ? $past(tx_bit_in) : 1'b1))
    else $error("framed ones wrong");
  a_rx_off: assert property (s_crit_off |=> !ais_defect) else $error("defect with criteria off");
  a_irq_rise: assert property (mask_q[0] && $rose(ais_defect) |-> irq) else $error("irq missing on defect");
  a_irq_masked: assert property (mask_q == 2'b00 [*2] |-> !irq) else $error("irq while masked");
endmodule
bind eais_top eais_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit_en(tx_bit_en),
  .tx_bit_in(tx_bit_in), .tx_frame_start(tx_frame_start), .tx_bit_out(tx_bit_out), .tx_bit_valid(tx_bit_valid),
  .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .rx_frame_start(rx_frame_start), .rx_in_frame(rx_in_frame),
  .ais_defect(ais_defect), .irq(irq));

// [tb/e1_ais_generate_detect_test.sv]
// Self-checking bench for the alarm indication generate and detect block.
`timescale 1ns/100ps
`include "eais_defines.vh"
module e1_ais_generate_detect_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        tx_bit_en, tx_bit_in, tx_frame_start, tx_bit_out, tx_bit_valid;
  logic        rx_bit_en, rx_bit, rx_frame_start, rx_in_frame, ais_defect, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  mode;
  logic [7:0]  tpos;
  int          errors, checks;
  eais_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit_en(tx_bit_en),
    .tx_bit_in(tx_bit_in), .tx_frame_start(tx_frame_start), .tx_bit_out(tx_bit_out), .tx_bit_valid(tx_bit_valid),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .rx_frame_start(rx_frame_start), .rx_in_frame(rx_in_frame),
    .ais_defect(ais_defect), .irq(irq));
  eais_far_end u_far (.pclk(pclk), .presetn(presetn), .mode(mode), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
    .rx_frame_start(rx_frame_start), .rx_in_frame(rx_in_frame));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Transmit traffic repeats 0011 so every timeslot carries four ones.
  always @(posedge pclk)
  begin
    tpos <= tpos + 8'h01;
    tx_bit_en <= presetn;
    tx_bit_in <= tpos[1];
    tx_frame_start <= (tpos == 8'h00);
  end
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      checks++;
      if (got !== exp)
      begin
        errors++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Each pass looks at pready as it stands at the rising edge; data are taken at that edge.
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
        chk("pready", 32'h1, {31'h0, pready});
        print_verdict;
      end
    end
  endtask
  task wait_defect(input logic exp);
    int n;
    begin
      n = 0;
      while (ais_defect !== exp && n < 1400)
      begin
        @(negedge pclk);
        n++;
      end
      chk("ais_defect", {31'h0, exp}, {31'h0, ais_defect});
      if (n == 1400)
        print_verdict;
    end
  endtask
  task test_regs;
    begin
      for (int i = 0; i < 4; i++)
      begin
        apb(1'b0, 12'(4 * i), 32'h0);
        chk("reset value", 32'h0, rd);
      end
      apb(1'b1, `EAIS_OFF_CTRL, 32'hffff_ffff);
      apb(1'b0, `EAIS_OFF_CTRL, 32'h0);
      chk("ctrl readback", 32'h0000_000f, rd);
      apb(1'b1, 12'h010, 32'hffff_ffff);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped error", 32'h1, {31'h0, er});
      apb(1'b1, `EAIS_OFF_CTRL, 32'h0);
      $display("test regs done");
    end
  endtask
  task test_irq;
    begin
      apb(1'b1, `EAIS_OFF_CTRL, 32'h1);
      mode <= 2'b01;
      wait_defect(1'b1);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, `EAIS_OFF_IRQ_STAT, 32'h0);
      chk("irq status", 32'h1, rd);
      apb(1'b0, `EAIS_OFF_STATUS, 32'h0);
      chk("status defect", 32'h1, rd);
      apb(1'b1, `EAIS_OFF_IRQ_MASK, 32'h3);
      repeat (2) @(negedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, `EAIS_OFF_IRQ_STAT, 32'h1);
      apb(1'b0, `EAIS_OFF_IRQ_STAT, 32'h0);
      chk("irq cleared", 32'h0, rd);
      chk("irq low", 32'h0, {31'h0, irq});
      $display("test irq done");
    end
  endtask
  task automatic test_tx;
    int n;
    int ones [4] = '{128, 256, 132, 252};
    begin
      for (int s = 0; s < 4; s++)
      begin
        apb(1'b1, `EAIS_OFF_CTRL, {28'h0, 2'(s), 2'b01});
        repeat (4) @(posedge pclk);
        n = 0;
        repeat (256) @(negedge pclk) n += int'(tx_bit_valid === 1'b1 && tx_bit_out === 1'b1);
        chk("tx ones per frame", 32'(ones[s]), 32'(n));
      end
      chk("defect held", 32'h1, {31'h0, ais_defect});
      $display("test tx done");
    end
  endtask
  task automatic test_detect;
    logic [1:0] crit [7] = '{2'b11, 2'b11, 2'b00, 2'b10, 2'b10, 2'b01, 2'b01};
    logic [1:0] pat [7] = '{2'b01, 2'b10, 2'b10, 2'b11, 2'b01, 2'b10, 2'b00};
    logic       exp [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    begin
      for (int i = 0; i < 7; i++)
      begin
        apb(1'b1, `EAIS_OFF_CTRL, {30'h0, crit[i]});
        mode <= pat[i];
        wait_defect(exp[i]);
      end
      $display("test detect done");
    end
  endtask
  task test_never;
    begin
      apb(1'b1, `EAIS_OFF_CTRL, 32'h0);
      mode <= 2'b01;
      repeat (1100) @(negedge pclk);
      chk("defect never", 32'h0, {31'h0, ais_defect});
      $display("test never done");
    end
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 2'b00;
    tpos = 8'h00;
    tx_bit_en = 1'b0;
    tx_bit_in = 1'b0;
    tx_frame_start = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_regs;
    test_irq;
    test_tx;
    test_detect;
    test_never;
    print_verdict;
  end
endmodule
